// ---- logic/oisi_pkg.sv ----
`default_nettype none
package oisi_pkg;

    // Line count and register port widths.
    localparam int LINE_N = 8;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // Register offsets on the plain register port.
    localparam logic [ADDR_W-1:0] ADDR_IDENT = 8'h01;
    localparam logic [ADDR_W-1:0] ADDR_VERSION = 8'h02;
    localparam logic [ADDR_W-1:0] ADDR_STATE_LINE3 = 8'h03;
    localparam logic [ADDR_W-1:0] ADDR_STATE_LINE1 = 8'h09;
    localparam logic [ADDR_W-1:0] ADDR_INVERT_LINE1 = 8'h0B;
    localparam logic [ADDR_W-1:0] ADDR_SUBVER = 8'h33;

    // Value limits and reset values.
    localparam logic [DATA_W-1:0] IDENT_ABSENT = 16'h0000;
    localparam logic [DATA_W-1:0] IDENT_MAX = 16'h0257;
    localparam logic [DATA_W-1:0] VERSION_MAX = 16'h270F;
    localparam logic [DATA_W-1:0] SUBVER_MAX = 16'h0063;
    localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;
    localparam logic [LINE_N-1:0] LINE_RESET = 8'h00;
    localparam int LINE3_INDEX = 2;

    // Status refresh timing.
    localparam int STATUS_PERIOD_MS = 4;
    localparam int CLK_FREQ_MHZ = 125;
    localparam int US_PER_MS = 1000;
    localparam int STATUS_TICK_CYCLES = STATUS_PERIOD_MS * US_PER_MS * CLK_FREQ_MHZ;
    localparam int TICK_W = 20;

    // Register port request.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } oisi_req_s;

    // Synchroniser state.
    typedef struct packed {
        logic [LINE_N-1:0] meta;
        logic [LINE_N-1:0] stable;
    } oisi_sync_s;

    // Refresh timer state.
    typedef struct packed {
        logic [TICK_W-1:0] cnt;
        logic tick;
    } oisi_tick_s;

    // Core state.
    typedef struct packed {
        logic loaded;
        logic [DATA_W-1:0] ident;
        logic [DATA_W-1:0] version;
        logic [DATA_W-1:0] subver;
        logic [LINE_N-1:0] invert_reg;
        logic [LINE_N-1:0] invert_act;
        logic [LINE_N-1:0] line_state;
        logic [LINE_N-1:0] line_value;
        logic [DATA_W-1:0] rdata;
    } oisi_core_s;

endpackage
`default_nettype wire

// ---- logic/oisi_sync.sv ----
`timescale 1ns/100ps
`default_nettype none
module oisi_sync
    import oisi_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Lines.
    input wire logic [LINE_N-1:0] line_in,
    output logic [LINE_N-1:0] line_sync
);

    oisi_sync_s q;
    oisi_sync_s d;

    // Two flops per line; only the second stage is read.
    always_comb
    begin
        d = q;
        d.meta = line_in; // RULE_11
        d.stable = q.meta; // RULE_11
    end

    // State register.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign line_sync = q.stable;

    // The stable stage shows the line two edges late.
    AST_SYNC_TWO_STAGE: assert property (@(posedge clk) disable iff (!rstn) // RULE_11
        ##2 (line_sync == $past(line_in, 2)))
        else $error("Synchroniser latency is not two cycles.");

endmodule
`default_nettype wire

// ---- logic/oisi_tick.sv ----
`timescale 1ns/100ps
`default_nettype none
module oisi_tick
    import oisi_pkg::*;
#(
    parameter int PERIOD = STATUS_TICK_CYCLES
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Refresh strobe.
    output logic tick
);

    localparam logic [TICK_W-1:0] LAST = TICK_W'(PERIOD - 1);

    oisi_tick_s q;
    oisi_tick_s d;

    // Free running counter with one pulse per period.
    always_comb
    begin
        d = q;
        d.tick = (q.cnt == LAST); // RULE_07
        if (q.cnt == LAST)
        begin
            d.cnt = '0;
        end
        else
        begin
            d.cnt = q.cnt + 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign tick = q.tick;

    // A strobe follows the last count of the period.
    AST_TICK_AT_WRAP: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
        (q.cnt == LAST) |=> (tick && q.cnt == '0))
        else $error("Refresh strobe missing at counter wrap.");

endmodule
`default_nettype wire

// ---- logic/oisi_core.sv ----
`timescale 1ns/100ps
`default_nettype none
// Operation
// RULE_01: Identity reads zero without a fitted module, else the fixed module identity.
// RULE_02: Identity is read-only, loaded once after reset, within 0 to 599.
// RULE_03: Host saves parameters and module identity only on its save command.
// RULE_04: Host trips at power-up on changed or missing module identity.
// RULE_05: Version reads as major.minor value plus a separate two-digit sub-version.
// RULE_06: Eight read-only state bits; offsets 3-8 lines 3-8, 9 line 1, 10 line 2.
// RULE_07: State bits refresh every 4 ms, 0 off, 1 on, reset to 0.
// RULE_08: State bits keep refreshing while fast update is selected.
// RULE_09: Eight read-write invert bits, reset off, sampled continuously in background.
// RULE_10: Each invert bit flips its own line's sense under standard update.
// RULE_11: Each line passes two synchroniser flops before capture.
module oisi_core
    import oisi_pkg::*;
#(
    parameter logic [DATA_W-1:0] MODULE_ID = 16'h0123, // Arbitrary identity value.
    parameter logic [DATA_W-1:0] SW_VERSION = 16'h0064,
    parameter logic [DATA_W-1:0] SW_SUBVER = 16'h0001,
    parameter int STATUS_TICKS = STATUS_TICK_CYCLES
)
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rstn,
    // Register port.
    input wire oisi_req_s req,
    output logic [DATA_W-1:0] rdata,
    // Slot and mode.
    input wire logic module_present,
    input wire logic fast_update_en,
    // Digital lines 1 to 8.
    input wire logic [LINE_N-1:0] digital_line_in,
    output logic [LINE_N-1:0] digital_line_value
);

    oisi_core_s q;
    oisi_core_s d;
    logic [LINE_N-1:0] line_sync;
    logic tick;

    // Address of the state bit for line index i.
    function automatic logic [ADDR_W-1:0] state_addr(input int i);
        logic [ADDR_W-1:0] a;
        a = ADDR_STATE_LINE1;
        if (i < LINE3_INDEX)
        begin
            a = ADDR_W'(ADDR_STATE_LINE1 + i);
        end
        else
        begin
            a = ADDR_W'(ADDR_STATE_LINE3 + i - LINE3_INDEX);
        end
        return a;
    endfunction

    // Address of the invert bit for line index i.
    function automatic logic [ADDR_W-1:0] invert_addr(input int i);
        return ADDR_W'(ADDR_INVERT_LINE1 + i);
    endfunction

    // Line synchroniser.
    oisi_sync u_sync (
        .clk(clk),
        .rstn(rstn),
        .line_in(digital_line_in),
        .line_sync(line_sync)
    );

    // Status refresh timer.
    oisi_tick #(
        .PERIOD(STATUS_TICKS)
    ) u_tick (
        .clk(clk),
        .rstn(rstn),
        .tick(tick)
    );

    // Next-state logic for load, refresh, invert sampling and the register port.
    always_comb
    begin
        logic hit;
        hit = 1'b0;
        d = q;
        // Fixed values are written once, on the first edge after reset.
        if (!q.loaded)
        begin
            d.loaded = 1'b1;
            d.ident = (MODULE_ID > IDENT_MAX) ? IDENT_MAX : MODULE_ID; // RULE_02
            d.version = (SW_VERSION > VERSION_MAX) ? VERSION_MAX : SW_VERSION; // RULE_05
            d.subver = (SW_SUBVER > SUBVER_MAX) ? SUBVER_MAX : SW_SUBVER; // RULE_05
        end
        // Invert settings are picked up by the logic every cycle.
        // The registered copy keeps the port's write timing out of the line path.
        d.invert_act = q.invert_reg; // RULE_09
        // Line states are captured on the refresh strobe whatever the mode.
        if (tick)
        begin
            d.line_state = line_sync; // RULE_07 RULE_08
        end
        // Fast update passes lines straight; standard update applies the inverts.
        if (fast_update_en)
        begin
            d.line_value = line_sync;
        end
        else
        begin
            d.line_value = line_sync ^ q.invert_act; // RULE_10
        end
        // Writes reach only the invert bits; all else is read-only.
        for (int i = 0; i < LINE_N; i++)
        begin
            if (req.wr && req.addr == invert_addr(i))
            begin
                d.invert_reg[i] = req.wdata[0]; // RULE_09
            end
        end
        // Read data stand for one cycle after the strobe, else zero.
        d.rdata = READ_IDLE;
        if (req.rd)
        begin
            if (req.addr == ADDR_IDENT)
            begin
                d.rdata = module_present ? q.ident : IDENT_ABSENT; // RULE_01
            end
            else if (req.addr == ADDR_VERSION)
            begin
                d.rdata = q.version; // RULE_05
            end
            else if (req.addr == ADDR_SUBVER)
            begin
                d.rdata = q.subver; // RULE_05
            end
            else
            begin
                // Only the first matching entry answers; the hit flag stops later ones.
                for (int i = 0; i < LINE_N; i++)
                begin
                    if (!hit && req.addr == state_addr(i))
                    begin
                        hit = 1'b1;
                        d.rdata = {{(DATA_W-1){1'b0}}, q.line_state[i]}; // RULE_06
                    end
                    else if (!hit && req.addr == invert_addr(i))
                    begin
                        hit = 1'b1;
                        d.rdata = {{(DATA_W-1){1'b0}}, q.invert_reg[i]}; // RULE_09
                    end
                end
            end
        end
    end

    // State register.
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign digital_line_value = q.line_value;

    // Identity reads zero with the slot empty.
    AST_IDENT_ABSENT: assert property (@(posedge clk) disable iff (!rstn) // RULE_01
        (req.rd && req.addr == ADDR_IDENT && !module_present) |=> (rdata == IDENT_ABSENT))
        else $error("Identity not zero with no module fitted.");

    // Identity reads the module value when fitted.
    AST_IDENT_PRESENT: assert property (@(posedge clk) disable iff (!rstn) // RULE_01
        (req.rd && req.addr == ADDR_IDENT && module_present && q.loaded) |=> (rdata == MODULE_ID))
        else $error("Identity wrong with module fitted.");

    // Identity never changes after loading and stays in range.
    AST_IDENT_FROZEN: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
        q.loaded |=> ($stable(q.ident) && q.ident <= IDENT_MAX))
        else $error("Identity changed after load.");

    // Version pair reads back the loaded values.
    AST_VERSION_READ: assert property (@(posedge clk) disable iff (!rstn) // RULE_05
        (req.rd && q.loaded && (req.addr == ADDR_VERSION || req.addr == ADDR_SUBVER))
        |=> (rdata == ($past(req.addr) == ADDR_VERSION ? SW_VERSION : SW_SUBVER)))
        else $error("Version read mismatch.");

    // Line 1 sits at the ninth state offset and line 3 at the third.
    AST_STATE_MAP: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
        (req.rd && (req.addr == ADDR_STATE_LINE1 || req.addr == ADDR_STATE_LINE3))
        |=> (rdata[0] == ($past(req.addr) == ADDR_STATE_LINE1 ? $past(q.line_state[0])
        : $past(q.line_state[LINE3_INDEX])) && rdata[DATA_W-1:1] == '0))
        else $error("State bit mapping wrong.");

    // States hold between strobes.
    AST_STATE_HOLD: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
        !tick |=> $stable(q.line_state))
        else $error("State changed without refresh strobe.");

    // States track the lines on each strobe even in fast mode.
    AST_STATE_TRACK: assert property (@(posedge clk) disable iff (!rstn) // RULE_08
        (tick && fast_update_en) |=> (q.line_state == $past(line_sync)))
        else $error("State not refreshed in fast mode.");

    // A written invert bit reaches the logic two cycles later.
    AST_INVERT_BG: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
        (req.wr && req.addr == ADDR_INVERT_LINE1) |-> ##2 (q.invert_act[0] == $past(req.wdata[0], 2)))
        else $error("Invert setting not sampled.");

    // Standard update applies the inverts per line.
    AST_STD_INVERT: assert property (@(posedge clk) disable iff (!rstn) // RULE_10
        !fast_update_en |=> (digital_line_value == ($past(line_sync) ^ $past(q.invert_act))))
        else $error("Standard update invert wrong.");

    // Read data fall back to zero after any cycle without a read strobe.
    AST_READ_IDLE: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
        !req.rd |=> (rdata == READ_IDLE))
        else $error("Read data did not return to zero.");

    // A write has no answer on the read data.
    AST_WRITE_NO_ANSWER: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
        (req.wr && !req.rd) |=> (rdata == READ_IDLE))
        else $error("Write produced read data.");

    // Addresses above the sub-version are unmapped and read as zero.
    AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
        (req.rd && req.addr > ADDR_SUBVER) |=> (rdata == READ_IDLE))
        else $error("Unmapped read returned data.");

    // Single-bit registers answer with all upper bits zero.
    AST_BIT_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
        (req.rd && req.addr >= ADDR_STATE_LINE3 && req.addr <= invert_addr(LINE_N-1))
        |=> (rdata[DATA_W-1:1] == '0))
        else $error("Upper bits set on a single-bit read.");

    // Writes to the identity are ignored, so software cannot alter the loaded value.
    AST_IDENT_WRITE: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
        (req.wr && req.addr == ADDR_IDENT) |=> $stable(q.ident))
        else $error("Identity altered by a write.");

    // The load flag never drops once set, so the fixed values are written only once.
    AST_LOADED_HOLD: assert property (@(posedge clk) disable iff (!rstn) // RULE_02
        q.loaded |=> q.loaded)
        else $error("Load flag dropped after power-up.");

    // Both version values stay fixed and in range after loading.
    AST_VERSION_FROZEN: assert property (@(posedge clk) disable iff (!rstn) // RULE_05
        q.loaded |=> ($stable(q.version) && $stable(q.subver)
        && q.version <= VERSION_MAX && q.subver <= SUBVER_MAX))
        else $error("Version values changed after load.");

    // The active invert copy trails the register by exactly one cycle.
    AST_INVERT_COPY: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
        ##1 (q.invert_act == $past(q.invert_reg)))
        else $error("Invert copy not refreshed.");

    // The refresh strobe lasts a single cycle.
    AST_TICK_SINGLE: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
        tick |=> !tick)
        else $error("Refresh strobe longer than one cycle.");

    // Per-line checks of the state bits, the invert bits and both update paths.
    for (genvar g = 0; g < LINE_N; g++)
    begin : g_line_chk
        // A state bit reads back in bit 0 with all upper bits zero.
        AST_STATE_READ: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
            (req.rd && req.addr == state_addr(g))
            |=> (rdata == {{(DATA_W-1){1'b0}}, $past(q.line_state[g])}))
            else $error("State bit read wrong.");

        // An invert bit reads back in bit 0 with all upper bits zero.
        AST_INVERT_READ: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
            (req.rd && req.addr == invert_addr(g))
            |=> (rdata == {{(DATA_W-1){1'b0}}, $past(q.invert_reg[g])}))
            else $error("Invert bit read wrong.");

        // A write to an invert bit lands on the next edge.
        AST_INVERT_WRITE: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
            (req.wr && req.addr == invert_addr(g)) |=> (q.invert_reg[g] == $past(req.wdata[0])))
            else $error("Invert bit write lost.");

        // A write elsewhere leaves the invert bit alone.
        AST_INVERT_KEEP: assert property (@(posedge clk) disable iff (!rstn) // RULE_09
            (req.wr && req.addr != invert_addr(g)) |=> $stable(q.invert_reg[g]))
            else $error("Invert bit changed by another write.");

        // Each strobe copies the synchronised line into its state bit, whatever the mode.
        AST_STATE_REFRESH: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
            tick |=> (q.line_state[g] == $past(line_sync[g])))
            else $error("State bit not refreshed on strobe.");

        // Standard update flips the line by its own invert bit.
        AST_STD_LINE: assert property (@(posedge clk) disable iff (!rstn) // RULE_10
            !fast_update_en |=> (digital_line_value[g] == ($past(line_sync[g]) ^ $past(q.invert_act[g]))))
            else $error("Line value wrong in standard update.");

        // Fast update passes the line without its invert.
        AST_FAST_PASS: assert property (@(posedge clk) disable iff (!rstn) // RULE_10
            fast_update_en |=> (digital_line_value[g] == $past(line_sync[g])))
            else $error("Line value wrong in fast update.");
    end

endmodule
`default_nettype wire

// ---- dv/oisi_host.sv ----
`timescale 1ns/100ps
`default_nettype none
// Host drive model: reads and writes option parameters and checks the fitted identity.
module oisi_host
    import oisi_pkg::*;
(
    // Clock.
    input wire logic clk,
    // Register port.
    output var oisi_req_s req,
    input wire logic [DATA_W-1:0] rdata
);
    logic [DATA_W-1:0] saved_id = IDENT_ABSENT;

    // The request starts idle.
    initial req = '0;

    // One-cycle write strobe; the data lines then move so no stale word lingers.
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req.wr <= 1'b0;
        req.wdata <= ~d;
    endtask

    // One-cycle read strobe; the answer is taken in the cycle after it.
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req.rd <= 1'b0;
        // The answer stands for the whole next cycle and is taken at its closing edge.
        @(posedge clk);
        d = rdata;
    endtask

    // The fitted identity is stored only on the save command value.
    task automatic save(input int cmd);
        logic [DATA_W-1:0] id;
        if (cmd == 1000)
        begin
            rd(ADDR_IDENT, id);
            saved_id = id;
        end
    endtask

    // Power-up check of the fitted identity against the stored one.
    task automatic power_check(output logic changed, output logic missing);
        logic [DATA_W-1:0] id;
        rd(ADDR_IDENT, id);
        missing = (saved_id != IDENT_ABSENT) && (id == IDENT_ABSENT);
        changed = (id != IDENT_ABSENT) && (id != saved_id);
    endtask
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module tb;
    import oisi_pkg::*;
    localparam int TICKS = 20;
    localparam logic [DATA_W-1:0] ID = 16'h0123; // Arbitrary identity value.
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic present = 1'b1;
    logic fast = 1'b0;
    logic [LINE_N-1:0] lines = 8'h00;
    logic [LINE_N-1:0] value;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] d;
    oisi_req_s req;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;

    oisi_core #(.MODULE_ID(ID), .STATUS_TICKS(TICKS)) dut (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata),
        .module_present(present), .fast_update_en(fast), .digital_line_in(lines), .digital_line_value(value));
    oisi_host host (.clk(clk), .req(req), .rdata(rdata));

    // Clock of 8 ns.
    initial forever #4 clk = ~clk;

    // Timeout guard.
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            stop_test();
        end
    end

    // Compares a value seen with the value expected.
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Reads a register and compares it.
    task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        host.rd(a, d);
        chk(d, exp);
    endtask

    // Checks all eight state bits against a line pattern.
    task automatic chk_states(input logic [LINE_N-1:0] p);
        for (int a = 3; a <= 10; a++)
            rchk(a[7:0], {15'h0000, p[(a <= 8) ? a - 1 : a - 9]});
    endtask

    // Prints counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Values after reset and an unmapped read.
    task automatic t_reset();
        rchk(ADDR_IDENT, ID);
        @(posedge clk);
        chk(rdata, READ_IDLE);
        rchk(ADDR_VERSION, 16'h0064);
        rchk(ADDR_SUBVER, 16'h0001);
        for (int a = 3; a <= 18; a++)
            rchk(a[7:0], 16'h0000);
        rchk(8'h40, READ_IDLE);
        chk({8'h00, value}, 16'h0000);
        $display("t_reset done");
    endtask

    // Identity is read-only, zero without a module, and checked by the host.
    task automatic t_ident();
        logic ch;
        logic ms;
        host.wr(ADDR_IDENT, 16'h0000);
        rchk(ADDR_IDENT, ID);
        host.save(999);
        host.power_check(ch, ms);
        chk({14'h0000, ch, ms}, 16'h0002);
        host.save(1000);
        @(posedge clk) present <= 1'b0;
        rchk(ADDR_IDENT, IDENT_ABSENT);
        host.power_check(ch, ms);
        chk({14'h0000, ch, ms}, 16'h0001);
        @(posedge clk) present <= 1'b1;
        host.power_check(ch, ms);
        chk({14'h0000, ch, ms}, 16'h0000);
        $display("t_ident done");
    endtask

    // State bits follow the lines after the refresh, never before the synchroniser.
    task automatic t_state();
        logic [LINE_N-1:0] old;
        logic [LINE_N-1:0] pats [2];
        pats = '{8'hA5, 8'h5A};
        for (int i = 0; i < 2; i++)
        begin
            old = lines;
            @(posedge clk) lines <= pats[i];
            rchk(ADDR_STATE_LINE1, {15'h0000, old[0]});
            repeat (TICKS + 6) @(posedge clk);
            chk_states(pats[i]);
        end
        host.wr(ADDR_STATE_LINE1, 16'h0001);
        rchk(ADDR_STATE_LINE1, 16'h0000);
        $display("t_state done");
    endtask

    // Invert bits flip the line value in standard mode only.
    task automatic t_invert();
        logic [LINE_N-1:0] inv = 8'h0F;
        for (int i = 0; i < 8; i++)
            host.wr(ADDR_INVERT_LINE1 + i[7:0], {15'h0000, inv[i]});
        for (int i = 0; i < 8; i++)
            rchk(ADDR_INVERT_LINE1 + i[7:0], {15'h0000, inv[i]});
        repeat (5) @(posedge clk);
        chk({8'h00, value}, {8'h00, lines ^ inv});
        @(posedge clk) fast <= 1'b1;
        repeat (5) @(posedge clk);
        chk({8'h00, value}, {8'h00, lines});
        @(posedge clk) lines <= 8'hC3;
        repeat (TICKS + 6) @(posedge clk);
        chk_states(8'hC3);
        $display("t_invert done");
    endtask

    // Main sequence.
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_ident();
        t_state();
        t_invert();
        stop_test();
    end
endmodule
`default_nettype wire
